// File: design/lcdcp_pkg.sv
// package: register map, field positions and counts for the lcd clock and power control
package lcdcp_pkg;
  // ==========================================================
  // register offsets on the local port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_WAVE = 3'h2;
  localparam logic [2:0] ADDR_CKSTP = 3'h3;
  // ==========================================================
  // reset values and bits that always read as one
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] WAVE_RST = 8'h60;
  localparam logic [7:0] WAVE_ONES = 8'h60;
  localparam logic [3:0] CKSTP_RST = 4'hF;
  // ==========================================================
  // field positions
  localparam int CTRL_PSW_B = 6;
  localparam int CTRL_ACT_B = 5;
  localparam int MODE_MRG_B = 2;
  localparam int WAVE_AB_B = 7;
  localparam int WAVE_SUP_B = 4;
  localparam int CKSTP_LCD_B = 0;
  // ==========================================================
  // last frame counts in source ticks and the fixed charge pulse codes
  localparam logic [7:0] FRAME_LAST_STD = 8'hFF;
  localparam logic [7:0] FRAME_LAST_THIRD = 8'hBF;
  localparam logic [3:0] CDS_FIXED_HIGH = 4'h0;
  localparam logic [3:0] CDS_FIXED_LOW = 4'h7;
  // ==========================================================
  // duty selection
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } lcdcp_duty_t;
  // decoded configuration carried through the block
  typedef struct packed {
    logic act;
    logic drive_supply_switch;
    logic [3:0] fsel;
    lcdcp_duty_t duty;
    logic merge;
    logic wave_b;
    logic sup_5v;
    logic [3:0] cds;
    logic lcd_run;
  } lcdcp_cfg_t;
endpackage : lcdcp_pkg

// File: design/lcdcp_top.sv
// lcd clock selection, frame timing, common drive, charge pulse and supply control
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module lcdcp_top (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic I_SYS_CLK_RUN,
  input wire logic I_WCLK_TICK,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_FRAME_TICK,
  output logic [3:0] O_COM,
  output logic O_POLARITY,
  output logic O_LADDER_CONNECT,
  output logic O_DRIVE_SUPPLY_ON,
  output logic O_SUPPLY_5V_SEL,
  output logic O_BOOST_EN,
  output logic [2:0] O_PERIPH_CLK_RUN
);
  // ==========================================================
  // reset release
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  // two stage release of the asynchronous reset
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  default clocking dclk @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // registers
  logic [6:0] ctrl_ff;
  logic [2:0] mode_ff;
  logic [7:0] wave_ff;
  logic [3:0] ckstp_ff;
  logic [7:0] rdata_ff;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_wave;
  logic wr_ckstp;
  logic [7:0] nxt_wave;
  logic [7:0] nxt_rdata;
  lcdcp_pkg::lcdcp_cfg_t cfg;

  // write decode
  assign wr_ctrl = I_CE && I_WR && (I_ADDR == lcdcp_pkg::ADDR_CTRL);
  assign wr_mode = I_CE && I_WR && (I_ADDR == lcdcp_pkg::ADDR_MODE);
  assign wr_wave = I_CE && I_WR && (I_ADDR == lcdcp_pkg::ADDR_WAVE);
  assign wr_ckstp = I_CE && I_WR && (I_ADDR == lcdcp_pkg::ADDR_CKSTP);
  assign nxt_wave = I_WDATA | lcdcp_pkg::WAVE_ONES;

  // register storage
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= lcdcp_pkg::CTRL_RST;
      mode_ff <= lcdcp_pkg::MODE_RST;
      wave_ff <= lcdcp_pkg::WAVE_RST;
      ckstp_ff <= lcdcp_pkg::CKSTP_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= I_WDATA[6:0];
      if (wr_mode) mode_ff <= I_WDATA[2:0];
      if (wr_wave) wave_ff <= nxt_wave;
      if (wr_ckstp) ckstp_ff <= I_WDATA[3:0];
    end
  end

  // read decode, unmapped addresses read zero
  assign nxt_rdata = !I_RD ? 8'h00 :
    (I_ADDR == lcdcp_pkg::ADDR_CTRL) ? {1'b1, ctrl_ff} :
    (I_ADDR == lcdcp_pkg::ADDR_MODE) ? {5'h00, mode_ff} :
    (I_ADDR == lcdcp_pkg::ADDR_WAVE) ? wave_ff :
    (I_ADDR == lcdcp_pkg::ADDR_CKSTP) ? {4'hF, ckstp_ff} : 8'h00;

  // read data stand for one cycle only
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (I_CE) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign O_RDATA = rdata_ff;

  // field view of the registers
  assign cfg.act = ctrl_ff[lcdcp_pkg::CTRL_ACT_B];
  assign cfg.drive_supply_switch = ctrl_ff[lcdcp_pkg::CTRL_PSW_B];
  assign cfg.fsel = ctrl_ff[3:0];
  assign cfg.duty = lcdcp_pkg::lcdcp_duty_t'(mode_ff[1:0]);
  assign cfg.merge = mode_ff[lcdcp_pkg::MODE_MRG_B];
  assign cfg.wave_b = wave_ff[lcdcp_pkg::WAVE_AB_B];
  assign cfg.sup_5v = wave_ff[lcdcp_pkg::WAVE_SUP_B];
  assign cfg.cds = wave_ff[3:0];
  assign cfg.lcd_run = ckstp_ff[lcdcp_pkg::CKSTP_LCD_B];

  // ==========================================================
  // clock source and frame timing
  logic sys_sel;
  logic src_ok;
  logic run;
  logic pre_en;
  logic [7:0] pre_last;
  logic [7:0] pre_ff;
  logic src_tick;
  logic [7:0] frm_ff;
  logic [7:0] frm_last;
  logic frame_end;
  logic slot_end;
  logic [1:0] slot;

  // stopped system clock gives no activity while it is the selected source
  assign sys_sel = cfg.fsel[3];
  assign src_ok = sys_sel ? I_SYS_CLK_RUN : 1'b1;
  // halt and standby gate the frame clock
  assign run = cfg.act && cfg.lcd_run && src_ok;

  // watch clock divide by 1, 2 or 4
  // system clock divide by 2 to 256
  assign pre_en = sys_sel ? 1'b1 : I_WCLK_TICK;
  assign pre_last = sys_sel ? 8'((9'h002 << cfg.fsel[2:0]) - 9'h001) :
    cfg.fsel[1] ? 8'h03 : cfg.fsel[0] ? 8'h01 : 8'h00;
  assign src_tick = run && pre_en && (pre_ff >= pre_last);

  // 256 ticks per frame, 192 at one third duty
  assign frm_last = (cfg.duty == lcdcp_pkg::DUTY_THIRD) ?
    lcdcp_pkg::FRAME_LAST_THIRD : lcdcp_pkg::FRAME_LAST_STD;
  assign frame_end = src_tick && (frm_ff >= frm_last);

  // prescaler and frame counter
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 8'h00;
      frm_ff <= 8'h00;
    end else if (wr_mode) begin // a duty change starts a fresh frame
      pre_ff <= 8'h00;
      frm_ff <= 8'h00;
    end else if (I_CE && run && pre_en) begin
      pre_ff <= src_tick ? 8'h00 : pre_ff + 8'h01;
      if (frame_end) frm_ff <= 8'h00;
      else if (src_tick) frm_ff <= frm_ff + 8'h01;
    end
  end

  // ==========================================================
  // common drive
  // slot timing per duty
  assign slot = (cfg.duty == lcdcp_pkg::DUTY_STATIC) ? 2'b00 :
    (cfg.duty == lcdcp_pkg::DUTY_HALF) ? {1'b0, frm_ff[7]} : frm_ff[7:6];
  assign slot_end = src_tick && (
    (cfg.duty == lcdcp_pkg::DUTY_STATIC) ? (frm_ff == 8'hFF) :
    (cfg.duty == lcdcp_pkg::DUTY_HALF) ? (frm_ff[6:0] == 7'h7F) :
    (frm_ff[5:0] == 6'h3F));

  logic pol_ff;
  logic nxt_pol;
  logic [3:0] com_act;
  logic [3:0] com_ff;

  // A inverts every slot, B every frame
  assign nxt_pol = cfg.wave_b ? (frame_end ? ~pol_ff : pol_ff) :
    (slot_end ? ~pol_ff : pol_ff);

  for (genvar gi = 0; gi < 4; gi++) begin : g_com
    logic [1:0] src_idx;
    logic in_duty;
    assign src_idx = !cfg.merge ? 2'(gi) :
      (cfg.duty == lcdcp_pkg::DUTY_STATIC) ? 2'b00 :
      (cfg.duty == lcdcp_pkg::DUTY_HALF) ? 2'(gi / 2) : 2'(gi);
    assign in_duty = (src_idx <= cfg.duty);
    assign com_act[gi] = run && in_duty && (slot == src_idx);
  end

  // common and polarity flops
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pol_ff <= 1'b0;
      com_ff <= 4'h0;
    end else if (I_CE) begin
      pol_ff <= nxt_pol;
      com_ff <= com_act;
    end
  end
  assign O_COM = com_ff;
  assign O_POLARITY = pol_ff;

  // ==========================================================
  // charge pulse and supply
  logic lad_raw;
  logic lad_ff;
  logic tick_ff;
  logic sup_on_ff;

  // charge pulse duty over 32 ticks
  assign lad_raw = (cfg.cds == lcdcp_pkg::CDS_FIXED_HIGH) ? 1'b1 :
    (cfg.cds == lcdcp_pkg::CDS_FIXED_LOW) ? 1'b0 :
    !cfg.cds[3] ? (frm_ff[4:2] < cfg.cds[2:0]) :
    !cfg.cds[2] ? (frm_ff[4:1] == 4'h0) : (frm_ff[4:0] == 5'h00);

  // ladder connect only in charge phase
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lad_ff <= 1'b0;
      tick_ff <= 1'b0;
      sup_on_ff <= 1'b0;
    end else if (I_CE) begin
      lad_ff <= run && lad_raw;
      tick_ff <= frame_end;
      sup_on_ff <= cfg.act && cfg.drive_supply_switch && cfg.lcd_run;
    end
  end
  assign O_LADDER_CONNECT = lad_ff;
  assign O_FRAME_TICK = tick_ff;
  assign O_DRIVE_SUPPLY_ON = sup_on_ff;
  // supply select and regulator enable together
  assign O_SUPPLY_5V_SEL = cfg.sup_5v;
  assign O_BOOST_EN = cfg.sup_5v;
  assign O_PERIPH_CLK_RUN = ckstp_ff[3:1];

  // ==========================================================
  // checks
  // fixed bits
  wave_fixed_a: assert property (wave_ff[6:5] == 2'b11)
    else $error("fixed waveform bits not one");
  boost_follow_a: assert property (
    wr_wave |=> (O_BOOST_EN == $past(I_WDATA[4])) && (O_SUPPLY_5V_SEL == O_BOOST_EN))
    else $error("regulator enable does not follow supply bit");
  standby_quiet_a: assert property (
    (I_CE && !cfg.lcd_run) |=> (com_ff == 4'h0) && !lad_ff && !tick_ff)
    else $error("activity in standby");
  halt_supply_a: assert property ((I_CE && !cfg.act) |=> !O_DRIVE_SUPPLY_ON)
    else $error("drive supply on while halted");
  sysclk_stop_a: assert property (
    (I_CE && sys_sel && !I_SYS_CLK_RUN) |=> !tick_ff && (com_ff == 4'h0))
    else $error("display active with system clock stopped");
  ladder_low_a: assert property (
    (I_CE && cfg.cds == lcdcp_pkg::CDS_FIXED_LOW) |=> !lad_ff)
    else $error("ladder connected at zero duty");
  ladder_high_a: assert property (
    (I_CE && run && cfg.cds == lcdcp_pkg::CDS_FIXED_HIGH) |=> lad_ff)
    else $error("ladder not connected at full duty");
  merge_static_a: assert property (
    (I_CE && cfg.merge && cfg.duty == lcdcp_pkg::DUTY_STATIC) |=> (&com_ff || ~|com_ff))
    else $error("merged static commons differ");
  sys_div_a: assert property ((cfg.fsel == 4'hF) |-> (pre_last == 8'hFF))
    else $error("system divider not 256");
  third_frame_a: assert property (
    (frame_end && cfg.duty == lcdcp_pkg::DUTY_THIRD) |-> (frm_ff == 8'hBF))
    else $error("third duty frame length wrong");
  std_frame_a: assert property (
    (frame_end && cfg.duty != lcdcp_pkg::DUTY_THIRD) |-> (frm_ff == 8'hFF))
    else $error("standard frame length wrong");
  watch_full_a: assert property (
    (run && !sys_sel && cfg.fsel[1:0] == 2'b00 && I_WCLK_TICK) |-> src_tick)
    else $error("watch tick not used undivided");
  watch_half_a: assert property (
    (!sys_sel && cfg.fsel[1:0] == 2'b01) |-> (pre_last == 8'h01))
    else $error("watch clock not halved");
  watch_quarter_a: assert property (
    (!sys_sel && cfg.fsel[1]) |-> (pre_last == 8'h03))
    else $error("watch clock not quartered");
  sys_div2_a: assert property (
    (cfg.fsel == 4'h8) |-> (pre_last == 8'h01))
    else $error("system divider not 2");
  wave_b_hold_a: assert property (
    (I_CE && cfg.wave_b && !frame_end) |=> $stable(O_POLARITY))
    else $error("B waveform flipped inside a frame");
  wave_a_flip_a: assert property (
    (I_CE && !cfg.wave_b && slot_end) |=> (O_POLARITY != $past(O_POLARITY)))
    else $error("A waveform did not flip at slot end");
  ladder_idle_a: assert property (
    (I_CE && !run) |=> !O_LADDER_CONNECT)
    else $error("ladder connected while stopped");
  ladder_16_a: assert property (
    (I_CE && run && cfg.cds[3:2] == 2'b10 && frm_ff[4:1] == 4'h0) |=> lad_ff)
    else $error("sixteenth pulse missing");
  ladder_32_a: assert property (
    (I_CE && run && cfg.cds[3:2] == 2'b11 && frm_ff[4:0] != 5'h00) |=> !lad_ff)
    else $error("thirty-second pulse too long");
  halt_quiet_a: assert property (
    (I_CE && !cfg.act) |=> (com_ff == 4'h0) && !lad_ff && !tick_ff)
    else $error("activity while halted");
  stby_supply_a: assert property (
    (I_CE && !cfg.lcd_run) |=> !O_DRIVE_SUPPLY_ON)
    else $error("drive supply on in standby");
  merge_half_a: assert property (
    (I_CE && run && cfg.merge && cfg.duty == lcdcp_pkg::DUTY_HALF) |=>
    (com_ff == 4'h3 || com_ff == 4'hC))
    else $error("merged half duty commons wrong");

endmodule : lcdcp_top

// File: bench/lcdcp_panel.sv
// panel model: frame period, ladder charge time and polarity flips
`timescale 1ns/1ps
module lcdcp_panel (
  input wire logic i_clk,
  input wire logic i_tick,
  input wire logic i_pol,
  input wire logic i_lad,
  output int o_frm,
  output int o_per,
  output int o_lhi,
  output int o_flp
);
  int cyc, hi, fl;
  logic pol_d;
  // ====
  // per-frame measurement, closed at each frame tick
  // charge time counts only while connected
  always @(posedge i_clk) begin
    pol_d <= i_pol;
    cyc <= cyc + 1;
    hi <= hi + int'(i_lad === 1'b1);
    fl <= fl + int'(i_pol !== pol_d);
    if (i_tick === 1'b1) begin
      o_frm <= o_frm + 1;
      o_per <= cyc + 1;
      o_lhi <= hi + int'(i_lad === 1'b1);
      o_flp <= fl + int'(i_pol !== pol_d);
      cyc <= 0;
      hi <= 0;
      fl <= 0;
    end
  end
endmodule : lcdcp_panel

// File: bench/tb_top.sv
// testbench: registers, frame timing, ladder duty, commons and standby
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  logic I_CLK_SYS, I_RESETN, I_SYS_CLK_RUN, I_WCLK_TICK, I_WR, I_RD;
  logic [2:0] I_ADDR, O_PERIPH_CLK_RUN;
  logic [7:0] I_WDATA, O_RDATA;
  logic [3:0] O_COM;
  logic O_FRAME_TICK, O_POLARITY, O_LADDER_CONNECT, O_DRIVE_SUPPLY_ON, O_SUPPLY_5V_SEL, O_BOOST_EN;
  int n_mismatch, check_count, frm, per, lhi, flp;
  lcdcp_top dut_u (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_CE(1'b1),
    .I_SYS_CLK_RUN(I_SYS_CLK_RUN), .I_WCLK_TICK(I_WCLK_TICK), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_FRAME_TICK(O_FRAME_TICK),
    .O_COM(O_COM), .O_POLARITY(O_POLARITY), .O_LADDER_CONNECT(O_LADDER_CONNECT),
    .O_DRIVE_SUPPLY_ON(O_DRIVE_SUPPLY_ON), .O_SUPPLY_5V_SEL(O_SUPPLY_5V_SEL),
    .O_BOOST_EN(O_BOOST_EN), .O_PERIPH_CLK_RUN(O_PERIPH_CLK_RUN));
  lcdcp_panel pnl_u (.i_clk(I_CLK_SYS), .i_tick(O_FRAME_TICK), .i_pol(O_POLARITY),
    .i_lad(O_LADDER_CONNECT), .o_frm(frm), .o_per(per), .o_lhi(lhi), .o_flp(flp));
  // ====
  // system clock and a fast watch tick, one pulse every two clocks
  initial begin
    I_CLK_SYS = 1'b0;
    forever #20 I_CLK_SYS = ~I_CLK_SYS;
  end
  always @(posedge I_CLK_SYS) I_WCLK_TICK <= ~I_WCLK_TICK;
  // ====
  // bus cycles and waits
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [2:0] a, input logic [7:0] ex);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1;
    `CHK("rdata", ex, O_RDATA)
  endtask : rdchk
  task automatic frames(input int n);
    int f0;
    f0 = frm;
    for (int i = 0; i < 20000 && frm < f0 + n; i++) @(posedge I_CLK_SYS);
    #1;
    // a frame count that never arrives is a mismatch
    if (frm < f0 + n) begin
      n_mismatch++;
      $display("ERROR frames exp %0d got %0d", f0 + n, frm);
    end
  endtask : frames
  task automatic idle(input int n);
    repeat (n) @(posedge I_CLK_SYS);
    #1;
  endtask : idle
  // ====
  // scenarios
  task automatic t_regs();
    rdchk(3'h2, 8'h60);
    rdchk(3'h3, 8'hFF);
    wr(3'h2, 8'h1F);
    rdchk(3'h2, 8'h7F);
    `CHK("boost", 1'b1, O_BOOST_EN)
    `CHK("sup5v", 1'b1, O_SUPPLY_5V_SEL)
    wr(3'h5, 8'hAA);
    rdchk(3'h5, 8'h00);
    wr(3'h2, 8'h90);
    rdchk(3'h2, 8'hF0);
    wr(3'h2, 8'h00);
    `CHK("boost", 1'b0, O_BOOST_EN)
  endtask : t_regs
  task automatic t_clk();
    logic [3:0] wc[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    int wm[5] = '{1, 2, 4, 4, 1};
    wr(3'h1, 8'h03);
    for (int n = 0; n < 3; n++) begin
      wr(3'h0, 8'h68 | 8'(n));
      frames(2);
      `CHK("sysdiv", 512 << n, per)
    end
    wr(3'h0, 8'h68);
    wr(3'h1, 8'h02);
    frames(2);
    `CHK("third", 384, per)
    wr(3'h1, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(3'h0, {4'h6, wc[i]});
      frames(2);
      `CHK("watch", 512 * wm[i], per)
    end
  endtask : t_clk
  task automatic t_stop();
    int f;
    wr(3'h0, 8'h68);
    @(posedge I_CLK_SYS);
    I_SYS_CLK_RUN <= 1'b0;
    idle(2);
    f = frm;
    idle(1100);
    `CHK("sysstop", f, frm)
    wr(3'h0, 8'h60);
    frames(2);
    `CHK("watchrun", 512, per)
    @(posedge I_CLK_SYS);
    I_SYS_CLK_RUN <= 1'b1;
    wr(3'h0, 8'h68);
  endtask : t_stop
  task automatic t_ladder();
    logic [3:0] cd[5] = '{4'h0, 4'h7, 4'h2, 4'h8, 4'hC};
    int hx[5] = '{512, 0, 128, 32, 16};
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, {4'h0, cd[i]});
      frames(2);
      `CHK("ladder", hx[i], lhi)
    end
  endtask : t_ladder
  task automatic t_wave();
    wr(3'h2, 8'h80);
    frames(2);
    `CHK("flip_b", 1, flp)
    wr(3'h2, 8'h00);
    frames(2);
    `CHK("flip_a", 4, flp)
  endtask : t_wave
  task automatic t_merge();
    int bad;
    int n_lo;
    int n_hi;
    wr(3'h1, 8'h04);
    frames(1);
    `CHK("com_static", 4'hF, O_COM)
    wr(3'h1, 8'h05);
    bad = 0;
    n_lo = 0;
    n_hi = 0;
    idle(2);
    repeat (600) begin
      @(posedge I_CLK_SYS);
      #1;
      if (O_COM === 4'h3) n_lo++;
      else if (O_COM === 4'hC) n_hi++;
      else bad++;
    end
    `CHK("com_half", 0, bad)
    `CHK("com_pairs", 1'b1, (n_lo > 0) && (n_hi > 0))
    wr(3'h1, 8'h04);
  endtask : t_merge
  task automatic t_standby();
    int f;
    `CHK("supply", 1'b1, O_DRIVE_SUPPLY_ON)
    wr(3'h3, 8'hF4);
    idle(2);
    f = frm;
    idle(1100);
    `CHK("stby_frm", f, frm)
    `CHK("stby_lad", 1'b0, O_LADDER_CONNECT)
    `CHK("stby_com", 4'h0, O_COM)
    `CHK("stby_sup", 1'b0, O_DRIVE_SUPPLY_ON)
    `CHK("periph", 3'b010, O_PERIPH_CLK_RUN)
    wr(3'h3, 8'hFF);
    idle(2);
    `CHK("supply", 1'b1, O_DRIVE_SUPPLY_ON)
    wr(3'h0, 8'h48);
    idle(2);
    f = frm;
    idle(1100);
    `CHK("act_frm", f, frm)
    `CHK("act_sup", 1'b0, O_DRIVE_SUPPLY_ON)
    rdchk(3'h0, 8'hC8);
    rdchk(3'h1, 8'h04);
  endtask : t_standby
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // ====
  // main sequence
  initial begin
    I_RESETN = 1'b0;
    I_SYS_CLK_RUN = 1'b1;
    I_WCLK_TICK = 1'b0;
    I_ADDR = 3'h0;
    I_WDATA = 8'h00;
    I_WR = 1'b0;
    I_RD = 1'b0;
    repeat (6) @(posedge I_CLK_SYS);
    I_RESETN <= 1'b1;
    idle(3);
    `CHK("periph", 3'b111, O_PERIPH_CLK_RUN)
    t_regs();
    t_clk();
    t_stop();
    t_ladder();
    t_wave();
    t_merge();
    t_standby();
    end_sim();
  end
  // watchdog well past the expected run length
  initial begin
    #(60000 * 40);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
